// *** inc/rqdd_pkg.sv ***
// rqdd_pkg: constants, field layout and state types for the request
// descriptor path between user logic and the transaction layer.
// assumes a 128-bit stream so the whole descriptor arrives in one beat.
//
// Behaviour
// - user opens each packet with 16-byte descriptor
// - core copies address type for memory, atomic
// - address type 00 raw, 01 xlate-req, 10 translated
// - user places Dword address in bits 63:2
// - user zeroes upper address on 32-bit requests
// - user sets first and last Dword byte masks
// - Dword count in bits 74:64, 1 to 256
// - user sets Dword count one for I/O
// - zero-length access: count one, first mask zero
// - core forwards Dword count without any checking
// - request type sits in bits 78:75
// - bit 79 set sends the request poisoned
// - user poisons only on detected payload error

package rqdd_pkg;

  // ==========================================================
  // stream geometry
  localparam int DATA_W = 128;
  localparam int KEEP_W = 4;
  localparam int BE_W = 4;
  localparam int BAND_W = 8;
  localparam int DWC_W = 11;
  localparam int DESC_BYTES = 16;

  // ==========================================================
  // descriptor field positions
  localparam int AT_LSB = 0;
  localparam int AT_MSB = 1;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 63;
  localparam int DWC_LSB = 64;
  localparam int DWC_MSB = 74;
  localparam int RTYPE_LSB = 75;
  localparam int RTYPE_MSB = 78;
  localparam int POISON_BIT = 79;

  // sideband layout: first mask low, last mask high
  localparam int FBE_LSB = 0;
  localparam int LBE_LSB = 4;

  // ==========================================================
  // address type codes
  localparam logic [1:0] AT_UNTRANSLATED = 2'h0;
  localparam logic [1:0] AT_XLATE_REQ = 2'h1;
  localparam logic [1:0] AT_TRANSLATED = 2'h2;
  localparam logic [1:0] AT_RESERVED = 2'h3;

  // ==========================================================
  // request type codes, plain defaults
  localparam logic [3:0] RT_MEM_RD = 4'h0;
  localparam logic [3:0] RT_MEM_WR = 4'h1;
  localparam logic [3:0] RT_IO_RD = 4'h2;
  localparam logic [3:0] RT_IO_WR = 4'h3;
  localparam logic [3:0] RT_ATOM_ADD = 4'h4;
  localparam logic [3:0] RT_ATOM_SWAP = 4'h5;
  localparam logic [3:0] RT_ATOM_CAS = 4'h6;

  // ==========================================================
  // counts and mask values
  localparam logic [DWC_W-1:0] DWC_MAX = 11'h100;
  localparam logic [DWC_W-1:0] DWC_ONE = 11'h001;
  localparam logic [BE_W-1:0] BE_ALL = 4'hf;
  localparam logic [BE_W-1:0] BE_NONE = 4'h0;
  localparam logic [KEEP_W-1:0] KEEP_ALL = 4'hf;

  // ==========================================================
  // state types
  typedef enum logic [1:0] {
    CS_DESC = 2'b01,
    CS_DATA = 2'b10
  } rqdd_core_st_e;

  typedef enum logic [1:0] {
    US_IDLE = 2'b01,
    US_DATA = 2'b10
  } rqdd_user_st_e;

endpackage

// *** inc/rqdd_if.sv ***
// rqdd_if: requester request stream between user end and core end.
// assumes both ends share one clock; no clocking block here.
`timescale 1ns/1ps
`default_nettype none

interface rqdd_if;
  import rqdd_pkg::*;

  logic tvalid;
  logic tready;
  logic tlast;
  logic [DATA_W-1:0] tdata;
  logic [KEEP_W-1:0] tkeep;
  logic [BAND_W-1:0] request_sideband_bus;

  // user application drives requests
  modport user (
    output tvalid,
    input tready,
    output tlast,
    output tdata,
    output tkeep,
    output request_sideband_bus
  );

  // core end accepts them
  modport core (
    input tvalid,
    output tready,
    input tlast,
    input tdata,
    input tkeep,
    input request_sideband_bus
  );

endinterface

`default_nettype wire

// *** src/rqdd_user_end.sv ***
// rqdd_user_end: user-side request builder; turns a request command plus
// a payload stream into descriptor and payload beats.
// assumes a 128-bit stream, byte address and byte length from user logic.
`timescale 1ns/1ps
`default_nettype none

module rqdd_user_end
  import rqdd_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  rqdd_if.user RQ,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [3:0] REQ_TYPE,
  input wire logic [1:0] REQ_AT,
  input wire logic [63:0] REQ_ADDR,
  input wire logic REQ_ADDR64,
  input wire logic [10:0] REQ_BYTES,
  input wire logic REQ_DATA_ERROR,
  input wire logic WR_VALID,
  output logic WR_READY,
  input wire logic [DATA_W-1:0] WR_DATA,
  input wire logic [KEEP_W-1:0] WR_KEEP,
  input wire logic WR_LAST,
  output logic REQ_REJECT
);

  // ==========================================================
  // state
  rqdd_user_st_e state_q;
  rqdd_user_st_e state_d;
  logic tvalid_q;
  logic tvalid_d;
  logic tlast_q;
  logic tlast_d;
  logic [DATA_W-1:0] tdata_q;
  logic [DATA_W-1:0] tdata_d;
  logic [KEEP_W-1:0] tkeep_q;
  logic [KEEP_W-1:0] tkeep_d;
  logic [BAND_W-1:0] band_q;
  logic [BAND_W-1:0] band_d;
  logic reject_q;
  logic reject_d;

  // ==========================================================
  // request classification
  logic is_io;
  logic is_atomic;
  logic is_mem;
  logic has_payload;
  logic zero_len;

  // type decode from the request command
  assign is_io = (REQ_TYPE == RT_IO_RD) || (REQ_TYPE == RT_IO_WR);
  assign is_atomic = (REQ_TYPE == RT_ATOM_ADD) || (REQ_TYPE == RT_ATOM_SWAP) || (REQ_TYPE == RT_ATOM_CAS);
  assign is_mem = (REQ_TYPE == RT_MEM_RD) || (REQ_TYPE == RT_MEM_WR);
  assign has_payload = (REQ_TYPE == RT_MEM_WR) || (REQ_TYPE == RT_IO_WR) || is_atomic;
  assign zero_len = (REQ_BYTES == 11'h000);

  // ==========================================================
  // length and byte masks
  logic [1:0] first_off;
  logic [11:0] span;
  logic [11:0] span_up;
  logic [11:0] dwc_raw;
  logic [DWC_W-1:0] dwc;
  logic [11:0] end_sum;
  logic [1:0] end_off;
  logic [BE_W-1:0] start_mask;
  logic [BE_W-1:0] end_mask;
  logic [BE_W-1:0] first_dword_byte_mask;
  logic [BE_W-1:0] last_dword_byte_mask;
  logic len_bad;

  // dword span of the byte range
  assign first_off = REQ_ADDR[1:0];
  assign span = {10'h000, first_off} + {1'b0, REQ_BYTES};
  assign span_up = span + 12'h003;
  assign dwc_raw = {2'h0, span_up[11:2]};
  assign end_sum = span - 12'h001;
  assign end_off = end_sum[1:0];
  assign start_mask = BE_W'(BE_ALL << first_off);
  assign end_mask = BE_W'(BE_ALL >> (2'h3 - end_off));
  assign len_bad = !zero_len && !is_io && (dwc_raw > {1'b0, DWC_MAX});

  // count: zero length and I/O both carry exactly one dword
  always_comb begin
    if (zero_len || is_io) begin
      dwc = DWC_ONE;
    end else begin
      dwc = dwc_raw[DWC_W-1:0];
    end
  end

  // valid bytes in first and last dword
  always_comb begin
    if (zero_len) begin
      first_dword_byte_mask = BE_NONE;
      last_dword_byte_mask = BE_NONE;
    end else if (dwc == DWC_ONE) begin
      first_dword_byte_mask = start_mask & end_mask;
      last_dword_byte_mask = BE_NONE;
    end else begin
      first_dword_byte_mask = start_mask;
      last_dword_byte_mask = end_mask;
    end
  end

  // ==========================================================
  // descriptor assembly
  logic [DATA_W-1:0] desc;

  // fields placed at their descriptor positions
  always_comb begin
    desc = '0;
    desc[AT_MSB:AT_LSB] = (is_mem || is_atomic) ? REQ_AT : AT_UNTRANSLATED;
    if (REQ_ADDR64) begin
      desc[ADDR_MSB:ADDR_LSB] = REQ_ADDR[63:2];
    end else begin
      desc[ADDR_MSB:ADDR_LSB] = {32'h00000000, REQ_ADDR[31:2]};
    end
    desc[DWC_MSB:DWC_LSB] = dwc;
    desc[RTYPE_MSB:RTYPE_LSB] = REQ_TYPE;
    desc[POISON_BIT] = REQ_DATA_ERROR && has_payload;
  end

  // ==========================================================
  // handshakes
  logic slot_free;
  logic req_take;
  logic wr_take;
  logic at_bad;

  // output slot empties when the core takes the beat
  assign slot_free = !tvalid_q || RQ.tready;
  assign REQ_READY = CE && (state_q == US_IDLE) && slot_free;
  assign WR_READY = CE && (state_q == US_DATA) && slot_free;
  assign req_take = REQ_VALID && REQ_READY;
  assign wr_take = WR_VALID && WR_READY;
  assign at_bad = (is_mem || is_atomic) && (REQ_AT == AT_RESERVED);

  // ==========================================================
  // next-state and beat loading
  always_comb begin
    state_d = state_q;
    tvalid_d = tvalid_q;
    tlast_d = tlast_q;
    tdata_d = tdata_q;
    tkeep_d = tkeep_q;
    band_d = band_q;
    reject_d = 1'b0;
    case (state_q)
      US_IDLE: begin
        if (req_take && (at_bad || len_bad)) begin
          reject_d = 1'b1;
          if (RQ.tready) begin
            tvalid_d = 1'b0;
          end
        end else if (req_take) begin
          // descriptor always leads the packet
          tvalid_d = 1'b1;
          tdata_d = desc;
          tkeep_d = KEEP_ALL;
          tlast_d = !has_payload;
          band_d = {last_dword_byte_mask, first_dword_byte_mask};
          if (has_payload) begin
            state_d = US_DATA;
          end
        end else if (RQ.tready) begin
          tvalid_d = 1'b0;
        end
      end
      US_DATA: begin
        if (wr_take) begin
          tvalid_d = 1'b1;
          tdata_d = WR_DATA;
          tkeep_d = WR_KEEP;
          tlast_d = WR_LAST;
          if (WR_LAST) begin
            state_d = US_IDLE;
          end
        end else if (RQ.tready) begin
          tvalid_d = 1'b0;
        end
      end
      default: begin
        state_d = US_IDLE;
        tvalid_d = 1'b0;
      end
    endcase
  end

  // registers, frozen while CE is low
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= US_IDLE;
      tvalid_q <= 1'b0;
      tlast_q <= 1'b0;
      tdata_q <= '0;
      tkeep_q <= '0;
      band_q <= '0;
      reject_q <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      tvalid_q <= tvalid_d;
      tlast_q <= tlast_d;
      tdata_q <= tdata_d;
      tkeep_q <= tkeep_d;
      band_q <= band_d;
      reject_q <= reject_d;
    end
  end

  // ==========================================================
  // outputs
  assign RQ.tvalid = tvalid_q;
  assign RQ.tlast = tlast_q;
  assign RQ.tdata = tdata_q;
  assign RQ.tkeep = tkeep_q;
  assign RQ.request_sideband_bus = band_q;
  assign REQ_REJECT = reject_q;

endmodule

`default_nettype wire

// *** src/rqdd_core_end.sv ***
// rqdd_core_end: core-side descriptor decoder; splits each request packet
// into header fields for the outgoing TLP and payload beats.
// assumes the transaction layer takes every output beat while TX_READY.
`timescale 1ns/1ps
`default_nettype none

module rqdd_core_end
  import rqdd_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  rqdd_if.core RQ,
  input wire logic TX_READY,
  output logic HDR_VALID,
  output logic [1:0] HDR_AT,
  output logic [61:0] HDR_ADDR,
  output logic [DWC_W-1:0] HDR_DWORD_COUNT,
  output logic [3:0] HDR_REQ_TYPE,
  output logic HDR_POISON,
  output logic [BE_W-1:0] HDR_FIRST_MASK,
  output logic [BE_W-1:0] HDR_LAST_MASK,
  output logic HDR_AT_REJECT,
  output logic PLD_VALID,
  output logic [DATA_W-1:0] PLD_DATA,
  output logic [KEEP_W-1:0] PLD_KEEP,
  output logic PLD_LAST
);

  // ==========================================================
  // state
  rqdd_core_st_e state_q;
  rqdd_core_st_e state_d;
  logic hv_q;
  logic hv_d;
  logic [1:0] at_q;
  logic [1:0] at_d;
  logic [61:0] addr_q;
  logic [61:0] addr_d;
  logic [DWC_W-1:0] dwc_q;
  logic [DWC_W-1:0] dwc_d;
  logic [3:0] rt_q;
  logic [3:0] rt_d;
  logic poi_q;
  logic poi_d;
  logic [BE_W-1:0] fbe_q;
  logic [BE_W-1:0] fbe_d;
  logic [BE_W-1:0] lbe_q;
  logic [BE_W-1:0] lbe_d;
  logic atrej_q;
  logic atrej_d;
  logic pv_q;
  logic pv_d;
  logic [DATA_W-1:0] pd_q;
  logic [DATA_W-1:0] pd_d;
  logic [KEEP_W-1:0] pk_q;
  logic [KEEP_W-1:0] pk_d;
  logic pl_q;
  logic pl_d;

  // ==========================================================
  // beat acceptance and type decode
  logic beat;
  logic [3:0] in_rt;
  logic [1:0] in_at;
  logic at_kept;

  assign RQ.tready = CE && TX_READY;
  assign beat = RQ.tvalid && RQ.tready;
  assign in_rt = RQ.tdata[RTYPE_MSB:RTYPE_LSB];
  assign in_at = RQ.tdata[AT_MSB:AT_LSB];
  assign at_kept = (in_rt == RT_MEM_RD) || (in_rt == RT_MEM_WR) || (in_rt == RT_ATOM_ADD)
    || (in_rt == RT_ATOM_SWAP) || (in_rt == RT_ATOM_CAS);

  // ==========================================================
  // next values: header on the first beat, payload after
  always_comb begin
    state_d = state_q;
    hv_d = 1'b0;
    at_d = at_q;
    addr_d = addr_q;
    dwc_d = dwc_q;
    rt_d = rt_q;
    poi_d = poi_q;
    fbe_d = fbe_q;
    lbe_d = lbe_q;
    atrej_d = 1'b0;
    pv_d = 1'b0;
    pd_d = pd_q;
    pk_d = pk_q;
    pl_d = 1'b0;
    case (state_q)
      CS_DESC: begin
        if (beat) begin
          hv_d = 1'b1;
          if (at_kept && (in_at != AT_RESERVED)) begin
            at_d = in_at;
          end else begin
            at_d = AT_UNTRANSLATED;
          end
          atrej_d = at_kept && (in_at == AT_RESERVED);
          addr_d = RQ.tdata[ADDR_MSB:ADDR_LSB];
          dwc_d = RQ.tdata[DWC_MSB:DWC_LSB];
          rt_d = in_rt;
          poi_d = RQ.tdata[POISON_BIT];
          fbe_d = RQ.request_sideband_bus[FBE_LSB +: BE_W];
          lbe_d = RQ.request_sideband_bus[LBE_LSB +: BE_W];
          if (!RQ.tlast) begin
            state_d = CS_DATA;
          end
        end
      end
      CS_DATA: begin
        if (beat) begin
          pv_d = 1'b1;
          pd_d = RQ.tdata;
          pk_d = RQ.tkeep;
          pl_d = RQ.tlast;
          if (RQ.tlast) begin
            state_d = CS_DESC;
          end
        end
      end
      default: begin
        state_d = CS_DESC;
      end
    endcase
  end

  // registers, frozen while CE is low
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= CS_DESC;
      hv_q <= 1'b0;
      at_q <= AT_UNTRANSLATED;
      addr_q <= '0;
      dwc_q <= '0;
      rt_q <= '0;
      poi_q <= 1'b0;
      fbe_q <= '0;
      lbe_q <= '0;
      atrej_q <= 1'b0;
      pv_q <= 1'b0;
      pd_q <= '0;
      pk_q <= '0;
      pl_q <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      hv_q <= hv_d;
      at_q <= at_d;
      addr_q <= addr_d;
      dwc_q <= dwc_d;
      rt_q <= rt_d;
      poi_q <= poi_d;
      fbe_q <= fbe_d;
      lbe_q <= lbe_d;
      atrej_q <= atrej_d;
      pv_q <= pv_d;
      pd_q <= pd_d;
      pk_q <= pk_d;
      pl_q <= pl_d;
    end
  end

  // ==========================================================
  // outputs
  assign HDR_VALID = hv_q;
  assign HDR_AT = at_q;
  assign HDR_ADDR = addr_q;
  assign HDR_DWORD_COUNT = dwc_q;
  assign HDR_REQ_TYPE = rt_q;
  assign HDR_POISON = poi_q;
  assign HDR_FIRST_MASK = fbe_q;
  assign HDR_LAST_MASK = lbe_q;
  assign HDR_AT_REJECT = atrej_q;
  assign PLD_VALID = pv_q;
  assign PLD_DATA = pd_q;
  assign PLD_KEEP = pk_q;
  assign PLD_LAST = pl_q;

endmodule

`default_nettype wire

// *** verification/rqdd_asserts.sv ***
// rqdd_asserts: wire checks on the user-to-core request stream.
// assumes it sits beside the interface in the bench top, one clock.
`timescale 1ns/1ps
`default_nettype none

module rqdd_asserts
  import rqdd_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic tvalid,
  input wire logic tready,
  input wire logic tlast,
  input wire logic [DATA_W-1:0] tdata,
  input wire logic [KEEP_W-1:0] tkeep,
  input wire logic [BAND_W-1:0] request_sideband_bus
);
  // ==========================================================
  // packet start tracking
  logic sop_q;
  logic sop_d;
  logic dsc;
  logic io;
  logic [3:0] rt;

  // a taken last beat makes the next beat a descriptor
  always_comb begin
    sop_d = sop_q;
    if (tvalid && tready) begin
      sop_d = tlast;
    end
  end

  // register start flag
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sop_q <= 1'b1;
    end else begin
      sop_q <= sop_d;
    end
  end

  // descriptor beat decode
  assign dsc = sop_q && tvalid;
  assign rt = tdata[RTYPE_MSB:RTYPE_LSB];
  assign io = (rt == RT_IO_RD) || (rt == RT_IO_WR);

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // ==========================================================
  // assertions
  hold_beat_a: assert property (tvalid && !tready |=> tvalid && $stable(tdata) && $stable(tlast))
    else $error("beat changed before taken");
  desc_keep_a: assert property (dsc |-> tkeep == KEEP_ALL)
    else $error("descriptor beat not full");
  at_legal_a: assert property (dsc |-> tdata[AT_MSB:AT_LSB] != AT_RESERVED)
    else $error("reserved address type sent");
  count_range_a: assert property (dsc |-> tdata[DWC_MSB:DWC_LSB] <= DWC_MAX)
    else $error("dword count above limit");
  io_count_a: assert property (dsc && io |-> tdata[DWC_MSB:DWC_LSB] == DWC_ONE)
    else $error("io count not one");
  other_at_a: assert property (dsc && (io || rt > RT_ATOM_CAS) |-> tdata[AT_MSB:AT_LSB] == AT_UNTRANSLATED)
    else $error("address type on other request");
  poison_pld_a: assert property (dsc && tdata[POISON_BIT] |-> !tlast)
    else $error("poison without payload");
  read_last_a: assert property (dsc && rt == RT_MEM_RD |-> tlast)
    else $error("read carries payload");
  zero_len_a: assert property (dsc && rt == RT_MEM_RD && request_sideband_bus[3:0] == BE_NONE
    |-> tdata[DWC_MSB:DWC_LSB] == DWC_ONE)
    else $error("zero length count not one");
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
// tb_top: both request ends joined, plus a bare core end fed by the bench.
// assumes the package, interface, design ends and checker compile first.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import rqdd_pkg::*;
;
  logic clk, sys_rst, ce, req_valid, req_a64, req_err, wr_valid, wr_last, tx_ready;
  logic req_ready, wr_ready, req_rej, hdr_valid, hdr_pois, pld_valid, pld_last, x_pois, x_rej;
  logic [3:0] req_type, wr_keep, hdr_type, hdr_fbe, hdr_lbe, x_fbe, pld_keep;
  logic [1:0] req_at, hdr_at, x_at;
  logic [63:0] req_addr;
  logic [61:0] hdr_addr;
  logic [10:0] req_bytes, hdr_cnt, x_cnt;
  logic [127:0] wr_data, pld_data;
  logic [87:0] hq[$];
  logic [132:0] pq[$];
  int miscompares, samples_checked, cyc, rejs, xr;

  rqdd_if rq_if();
  rqdd_if raw_if();

  rqdd_user_end rqdd_user_end_i (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .RQ(rq_if), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_TYPE(req_type), .REQ_AT(req_at), .REQ_ADDR(req_addr), .REQ_ADDR64(req_a64),
    .REQ_BYTES(req_bytes), .REQ_DATA_ERROR(req_err), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .WR_DATA(wr_data), .WR_KEEP(wr_keep), .WR_LAST(wr_last), .REQ_REJECT(req_rej));
  rqdd_core_end rqdd_core_end_i (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .RQ(rq_if), .TX_READY(tx_ready),
    .HDR_VALID(hdr_valid), .HDR_AT(hdr_at), .HDR_ADDR(hdr_addr), .HDR_DWORD_COUNT(hdr_cnt),
    .HDR_REQ_TYPE(hdr_type), .HDR_POISON(hdr_pois), .HDR_FIRST_MASK(hdr_fbe), .HDR_LAST_MASK(hdr_lbe),
    .HDR_AT_REJECT(), .PLD_VALID(pld_valid), .PLD_DATA(pld_data), .PLD_KEEP(pld_keep), .PLD_LAST(pld_last));
  rqdd_core_end rqdd_core_end_x_i (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .RQ(raw_if), .TX_READY(tx_ready),
    .HDR_VALID(), .HDR_AT(x_at), .HDR_ADDR(), .HDR_DWORD_COUNT(x_cnt), .HDR_REQ_TYPE(), .HDR_POISON(x_pois),
    .HDR_FIRST_MASK(x_fbe), .HDR_LAST_MASK(), .HDR_AT_REJECT(x_rej), .PLD_VALID(), .PLD_DATA(), .PLD_KEEP(),
    .PLD_LAST());
  rqdd_asserts rqdd_asserts_i (.CLK(clk), .SYS_RST(sys_rst), .tvalid(rq_if.tvalid), .tready(rq_if.tready),
    .tlast(rq_if.tlast), .tdata(rq_if.tdata), .tkeep(rq_if.tkeep),
    .request_sideband_bus(rq_if.request_sideband_bus));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // capture outputs on enabled edges, stall the far side, freeze both ends now and then
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tx_ready <= (cyc % 3 != 0);
    ce <= (cyc % 7 != 5);
    if (hdr_valid && ce) hq.push_back({hdr_at, hdr_addr, hdr_cnt, hdr_type, hdr_pois, hdr_fbe, hdr_lbe});
    if (pld_valid && ce) pq.push_back({pld_keep, pld_last, pld_data});
    if (req_rej && ce) rejs++;
    if (x_rej && ce) xr++;
    if (cyc == 4000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [128:0] seen, input logic [128:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected header from the request command
  function automatic logic [87:0] exp_hdr(input logic [3:0] t, input logic [1:0] at, input logic [63:0] ad,
    input logic a64, input logic [10:0] by, input logic er);
    logic [63:0] a;
    logic [12:0] e;
    logic [10:0] c;
    logic [3:0] f;
    logic [3:0] l;
    a = a64 ? ad : {32'h0, ad[31:0]};
    e = 13'(a[1:0]) + 13'(by);
    c = (by == 11'h0 || t inside {RT_IO_RD, RT_IO_WR}) ? 11'h1 : 11'((e + 13'h3) >> 2);
    f = (by == 11'h0) ? 4'h0 : 4'hf << a[1:0];
    l = 4'hf >> (2'h3 - 2'(e - 13'h1));
    if (c == 11'h1) begin
      f = f & l;
      l = 4'h0;
    end
    return {(t inside {RT_MEM_RD, RT_MEM_WR, RT_ATOM_ADD, RT_ATOM_SWAP, RT_ATOM_CAS}) ? at : 2'h0, a[63:2], c, t,
      er && t inside {RT_MEM_WR, RT_IO_WR, RT_ATOM_ADD, RT_ATOM_SWAP, RT_ATOM_CAS}, f, l};
  endfunction

  // issue one request command, held until taken
  task automatic run(input logic [3:0] t, input logic [1:0] at, input logic [63:0] ad, input logic [10:0] by,
    input logic er);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_type <= t;
    req_at <= at;
    req_addr <= ad;
    req_a64 <= ad[40];
    req_bytes <= by;
    req_err <= er;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
  endtask

  // request, optional one-beat payload, then header and payload checks
  task automatic scen(input logic [3:0] t, input logic [1:0] at, input logic [63:0] ad, input logic [10:0] by,
    input logic er, input logic wr);
    int n;
    logic [132:0] p;
    run(t, at, ad, by, er);
    if (wr) begin
      @(posedge clk);
      wr_valid <= 1'b1;
      wr_data <= {4{ad[31:0]}};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (wr_ready !== 1'b1 && n < 50);
      wr_valid <= 1'b0;
    end
    n = 0;
    while ((hq.size() == 0 || (wr && pq.size() == 0)) && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk(129'(hq.pop_front()), 129'(exp_hdr(t, at, ad, ad[40], by, er)));
    if (wr) begin
      p = pq.pop_front();
      chk(p[128:0], {1'b1, {4{ad[31:0]}}});
      chk(129'(p[132:129]), 129'(KEEP_ALL));
    end
  endtask

  // request that the user end must drop
  task automatic drop(input logic [1:0] at, input logic [10:0] by);
    int r0;
    r0 = rejs;
    run(RT_MEM_RD, at, 64'h100, by, 1'b0);
    repeat (3) @(posedge clk);
    chk(129'(rejs - r0), 129'(1));
    chk(129'(hq.size()), 129'(0));
  endtask

  // main sequence
  initial begin
    int n;
    {sys_rst, req_valid, req_a64, req_err, wr_valid, tx_ready, req_type, req_at, req_addr, req_bytes} = '0;
    {wr_last, wr_keep, wr_data, cyc, rejs, xr, miscompares, samples_checked} = '0;
    sys_rst = 1'b1;
    ce = 1'b1;
    wr_last = 1'b1;
    wr_keep = KEEP_ALL;
    {raw_if.tvalid, raw_if.tlast, raw_if.tdata, raw_if.tkeep, raw_if.request_sideband_bus} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    scen(RT_MEM_WR, AT_UNTRANSLATED, 64'h1234_5678_0000_0010, 11'h10, 1'b1, 1'b1);
    scen(RT_MEM_RD, AT_TRANSLATED, 64'h1234_5778_0000_0103, 11'h6, 1'b1, 1'b0);
    for (int i = 0; i < 7; i++) begin
      scen(4'(i), AT_TRANSLATED, 64'h40, (i inside {2, 3}) ? 11'h4 : 11'h8, 1'b1, i inside {1, 3, 4, 5, 6});
    end
    for (int i = 0; i < 3; i++) begin
      scen(RT_MEM_RD, 2'(i), 64'h48, 11'h8, 1'b0, 1'b0);
    end
    scen(RT_IO_RD, AT_XLATE_REQ, 64'h21, 11'h2, 1'b0, 1'b0);
    scen(RT_MEM_RD, AT_UNTRANSLATED, 64'h0, 11'h0, 1'b0, 1'b0);
    scen(RT_MEM_RD, AT_UNTRANSLATED, 64'h0, 11'h400, 1'b0, 1'b0);
    drop(AT_RESERVED, 11'h8);
    drop(AT_UNTRANSLATED, 11'h404);
    @(posedge clk);
    raw_if.tvalid <= 1'b1;
    raw_if.tlast <= 1'b1;
    raw_if.tkeep <= KEEP_ALL;
    raw_if.request_sideband_bus <= 8'h3c;
    raw_if.tdata <= {48'h0, 1'b1, RT_MEM_WR, 11'h12c, 62'h5, AT_RESERVED};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (raw_if.tready !== 1'b1 && n < 50);
    raw_if.tvalid <= 1'b0;
    raw_if.tdata <= ~raw_if.tdata;
    repeat (3) @(posedge clk);
    chk(129'({x_at, x_cnt, x_pois, x_fbe}), 129'({2'h0, 11'h12c, 1'b1, 4'hc}));
    chk(129'(xr), 129'(1));
    wrap_up();
  end
endmodule

`default_nettype wire
